// *** inc/vic_defs.svh ***
`ifndef VIC_DEFS_SVH
`define VIC_DEFS_SVH

////////////////////////////////////////////////////////////////////////////
// register offsets (byte addresses on the register bus)
`define VIC_OFF_REQ      8'h00
`define VIC_OFF_ENA      8'h04
`define VIC_OFF_EDGE     8'h08
`define VIC_OFF_SEL      8'h0c
`define VIC_OFF_STAT     8'h10

////////////////////////////////////////////////////////////////////////////
// maskable request lines, highest priority first
`define VIC_NSRC         15
`define VIC_NPIN         8

// source-select register fields
`define VIC_SEL_SIO2     0
`define VIC_SEL_SIO1     1
`define VIC_SEL_SHORT    2
`define VIC_SEL_OVER     3
`define VIC_SEL_WAKE     4
`define VIC_SEL_INTEG    5
`define VIC_SEL_W        6

// status register fields
`define VIC_STAT_IFLAG   0
`define VIC_STAT_BUSY    1
`define VIC_STAT_BRK     2
`define VIC_STAT_LAST    8

////////////////////////////////////////////////////////////////////////////
// reset values
`define VIC_RST_ENA      15'h0000
`define VIC_RST_EDGE     8'h00
`define VIC_RST_SEL      6'h00
`define VIC_RST_STACKPG  8'h01

////////////////////////////////////////////////////////////////////////////
// vector table: low byte address, high byte one above
`define VIC_VEC_RESET    16'hfffc
`define VIC_VEC_FIRST    16'hfffa
`define VIC_VEC_BRK      16'hffdc

`endif

// *** inc/vic_pkg.sv ***
package vic_pkg;

  typedef enum logic [6:0] {
    VIC_IDLE     = 7'b0000001,
    VIC_PUSH_PCH = 7'b0000010,
    VIC_PUSH_PCL = 7'b0000100,
    VIC_PUSH_PS  = 7'b0001000,
    VIC_VEC_LO   = 7'b0010000,
    VIC_VEC_HI   = 7'b0100000,
    VIC_LOAD     = 7'b1000000
  } vic_state_e;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } vic_mem_s;

  typedef struct packed {
    logic i2c_done;
    logic sio2_rx_done;
    logic tmr_x_uflow;
    logic tmr_y_uflow;
    logic tmr_1_uflow;
    logic tmr_2_uflow;
    logic sio1_rx_done;
    logic sio1_tx_event;
    logic short_det;
    logic over_det;
    logic wake_det;
    logic ad_done;
    logic integ_done;
  } vic_evt_s;

endpackage

// *** verilog/vic_edge.sv ***
module vic_edge #(
  parameter int N = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [N-1:0] pin,
  input  wire logic [N-1:0] falling,
  output logic      [N-1:0] hit
);
  logic [N-1:0] sync1_q;
  logic [N-1:0] sync2_q;
  logic [N-1:0] prev_q;
  logic [N-1:0] cur;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= pin;
      sync2_q <= sync1_q;
    end
  end

  // polarity folded in before the edge test, so flipping it can hit
  assign cur = sync2_q ^ falling;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prev_q <= '0;
    end else begin
      prev_q <= cur;
    end
  end

  assign hit = cur & ~prev_q;
endmodule

// *** verilog/vic_prio.sv ***
module vic_prio #(
  parameter int N = 15
) (
  input  wire logic [N-1:0] eligible,
  output logic              valid,
  output logic [3:0]        idx
);
  always_comb begin
    valid = 1'b0;
    idx   = 4'h0;
    for (int i = N - 1; i >= 0; i--) begin
      if (eligible[i]) begin
        valid = 1'b1;
        idx   = 4'(i);
      end
    end
  end
endmodule

// *** verilog/vic_top.sv ***
// Summary of operation
// RULE1 - on acceptance push program counter and status onto the stack first
// RULE2 - on acceptance set the global mask flag and clear the source request
// RULE3 - on acceptance load the source vector table entry into the counter
// RULE4 - software disables, changes edge, clears request, then re-enables
// RULE5 - reset is top priority, non-maskable, vector at fffd/fffc
// RULE6 - external input zero edge requests at priority 2, vector fffb/fffa
// RULE7 - scl or sda edge requests at priority 3, vector fff9/fff8
// RULE8 - external input one edge requests at priority 4, vector fff7/fff6
// RULE9 - external input two edge requests at priority 5, vector fff5/fff4
// RULE10 - external input three edge requests at priority 6, fff3/fff2
// RULE11 - i2c done or second serial receive share priority 7, fff1/fff0
// RULE12 - timer x underflow priority 8 at ffef, timer y priority 9 at ffed
// RULE13 - timer 1 underflow priority 10 at ffeb, timer 2 priority 11 ffe9
// RULE14 - first serial receive or transmit share priority 12, ffe7/ffe6
// RULE15 - short, over or wake current request priority 13, ffe5/ffe4
// RULE16 - counter pin zero edge priority 14 ffe3, pin one 15 ffe1
// RULE17 - a/d done or integration end share priority 16, ffdf/ffde
// RULE18 - break instruction is non-maskable lowest priority 17, ffdd/ffdc
// RULE19 - maskable source serviced only when request, enable set, mask clear
// RULE20 - software clears request bits, never sets them; enables read-write
// RULE21 - break ignores mask and enables; mask blocks every other source except reset
// RULE22 - simultaneous requests are taken in fixed priority order
// RULE23 - requests stay until taken or cleared; best picked per boundary
// RULE24 - a select bit decides which source drives a shared request line
//
// Chosen here: the APB register port and the register offsets.
`include "vic_defs.svh"

module vic_top (
  input  wire logic              CORE_CLK,
  input  wire logic              RST_B,
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [7:0]        PADDR,
  input  wire logic [31:0]       PWDATA,
  output logic      [31:0]       PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  input  wire logic [3:0]        EXT_IRQ_PINS,
  input  wire logic              SCL_PIN,
  input  wire logic              SDA_PIN,
  input  wire logic              COUNTER_PIN_ZERO,
  input  wire logic              COUNTER_PIN_ONE,
  input  wire vic_pkg::vic_evt_s EVENTS,
  input  wire logic              SOFT_BREAK_INSTRUCTION,
  input  wire logic              CORE_BOUNDARY,
  input  wire logic [15:0]       CORE_PC,
  input  wire logic [7:0]        CORE_PS,
  input  wire logic [7:0]        CORE_SP,
  input  wire logic              CORE_SET_I,
  input  wire logic              CORE_CLR_I,
  output vic_pkg::vic_mem_s      MEM,
  input  wire logic              MEM_ACK,
  input  wire logic [7:0]        MEM_RDATA,
  output logic                   CORE_HOLD,
  output logic                   PC_LOAD,
  output logic      [15:0]       PC_VALUE,
  output logic                   SP_LOAD,
  output logic      [7:0]        SP_VALUE,
  output logic                   IRQ_DISABLE
);
  import vic_pkg::*;

  localparam int N = `VIC_NSRC;

  function automatic logic [15:0] vec_of(input logic [3:0] idx);
    vec_of = `VIC_VEC_FIRST - {11'h000, idx, 1'b0};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // registers and state
  logic [N-1:0]            req_q;
  logic [N-1:0]            ena_q;
  logic [`VIC_NPIN-1:0]    edge_q;
  logic [`VIC_SEL_W-1:0]   sel_q;
  logic                    iflag_q;
  logic                    brk_q;
  logic                    rst_pend_q;
  logic                    from_rst_q;
  logic [3:0]              last_q;
  vic_state_e              state_q;
  vic_state_e              state_d;
  vic_mem_s                mem_q;
  vic_mem_s                mem_d;
  logic [15:0]             pc_q;
  logic [7:0]              ps_q;
  logic [7:0]              sp_q;
  logic [15:0]             vec_q;
  logic [15:0]             newpc_q;
  logic [31:0]             prdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // pin edge detection
  logic [`VIC_NPIN-1:0] pins;
  logic [`VIC_NPIN-1:0] hit;

  assign pins = {COUNTER_PIN_ONE, COUNTER_PIN_ZERO, SDA_PIN, SCL_PIN,
                 EXT_IRQ_PINS};

  vic_edge #(.N(`VIC_NPIN)) u_edge (
    .clk     (CORE_CLK),
    .rst_b   (RST_B),
    .pin     (pins),
    .falling (edge_q),   // see RULE4
    .hit     (hit)
  );

  ////////////////////////////////////////////////////////////////////////////
  // request line sources
  logic [N-1:0] set;

  always_comb begin
    set     = '0;
    set[0]  = hit[0];                                   // see RULE6
    set[1]  = hit[4] | hit[5];                          // see RULE7
    set[2]  = hit[1];                                   // see RULE8
    set[3]  = hit[2];                                   // see RULE9
    set[4]  = hit[3];                                   // see RULE10
    set[5]  = sel_q[`VIC_SEL_SIO2] ? EVENTS.sio2_rx_done
                                   : EVENTS.i2c_done;   // see RULE11 RULE24
    set[6]  = EVENTS.tmr_x_uflow;                       // see RULE12
    set[7]  = EVENTS.tmr_y_uflow;                       // see RULE12
    set[8]  = EVENTS.tmr_1_uflow;                       // see RULE13
    set[9]  = EVENTS.tmr_2_uflow;                       // see RULE13
    set[10] = sel_q[`VIC_SEL_SIO1] &
              (EVENTS.sio1_rx_done | EVENTS.sio1_tx_event); // see RULE14
    set[11] = (sel_q[`VIC_SEL_SHORT] & EVENTS.short_det) |
              (sel_q[`VIC_SEL_OVER]  & EVENTS.over_det)  |
              (sel_q[`VIC_SEL_WAKE]  & EVENTS.wake_det);    // see RULE15
    set[12] = hit[6];                                   // see RULE16
    set[13] = hit[7];                                   // see RULE16
    set[14] = sel_q[`VIC_SEL_INTEG] ? EVENTS.integ_done
                                    : EVENTS.ad_done;   // see RULE17 RULE24
  end

  ////////////////////////////////////////////////////////////////////////////
  // arbitration
  logic [N-1:0] eligible;
  logic         mask_valid;
  logic [3:0]   mask_idx;
  logic         take;
  logic         take_mask;
  logic         take_brk;

  assign eligible = req_q & ena_q & {N{~iflag_q}};      // see RULE19 RULE21

  vic_prio #(.N(N)) u_prio (
    .eligible (eligible),
    .valid    (mask_valid),
    .idx      (mask_idx)
  );

  assign take      = (state_q == VIC_IDLE) & CORE_BOUNDARY & ~rst_pend_q;
  assign take_mask = take & mask_valid;                  // see RULE22 RULE23
  assign take_brk  = take & ~mask_valid & brk_q;         // see RULE18 RULE21

  ////////////////////////////////////////////////////////////////////////////
  // apb decode
  logic wr;
  logic rd_setup;
  logic mapped;

  assign wr       = PSEL & PENABLE & PWRITE;
  assign rd_setup = PSEL & ~PENABLE;
  assign mapped   = (PADDR == `VIC_OFF_REQ)  | (PADDR == `VIC_OFF_ENA) |
                    (PADDR == `VIC_OFF_EDGE) | (PADDR == `VIC_OFF_SEL) |
                    (PADDR == `VIC_OFF_STAT);

  ////////////////////////////////////////////////////////////////////////////
  // request bits: set wins over any clear
  logic [N-1:0] clr;

  always_comb begin
    clr = '0;
    if (wr && PADDR == `VIC_OFF_REQ) begin
      clr = ~PWDATA[N-1:0];                              // see RULE20
    end
    if (take_mask) begin
      clr[mask_idx] = 1'b1;                              // see RULE2
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      req_q <= '0;
    end else begin
      req_q <= (req_q & ~clr) | set;                     // see RULE23
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ena_q  <= `VIC_RST_ENA;
      edge_q <= `VIC_RST_EDGE;
      sel_q  <= `VIC_RST_SEL;
    end else if (wr) begin
      if (PADDR == `VIC_OFF_ENA) begin
        ena_q <= PWDATA[N-1:0];                          // see RULE20
      end
      if (PADDR == `VIC_OFF_EDGE) begin
        edge_q <= PWDATA[`VIC_NPIN-1:0];
      end
      if (PADDR == `VIC_OFF_SEL) begin
        sel_q <= PWDATA[`VIC_SEL_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mask flag, break and reset pending
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      iflag_q <= 1'b1;
    end else if (take_mask || take_brk || state_q == VIC_LOAD) begin
      iflag_q <= 1'b1;                                   // see RULE2
    end else if (CORE_SET_I) begin
      iflag_q <= 1'b1;
    end else if (CORE_CLR_I) begin
      iflag_q <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      brk_q <= 1'b0;
    end else if (SOFT_BREAK_INSTRUCTION) begin
      brk_q <= 1'b1;
    end else if (take_brk) begin
      brk_q <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_pend_q <= 1'b1;                                // see RULE5
      from_rst_q <= 1'b1;
    end else begin
      if (rst_pend_q && state_q == VIC_IDLE) begin
        rst_pend_q <= 1'b0;
      end
      if (take_mask || take_brk) begin
        from_rst_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // context capture at acceptance
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      pc_q   <= 16'h0000;
      ps_q   <= 8'h00;
      vec_q  <= `VIC_VEC_RESET;
      last_q <= 4'h0;
    end else if (take_mask) begin
      pc_q   <= CORE_PC;
      ps_q   <= CORE_PS;
      vec_q  <= vec_of(mask_idx);                        // see RULE3
      last_q <= mask_idx;
    end else if (take_brk) begin
      pc_q   <= CORE_PC;
      ps_q   <= CORE_PS;
      vec_q  <= `VIC_VEC_BRK;
      last_q <= 4'hf;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // service sequencer
  logic acked;

  assign acked = mem_q.req & MEM_ACK;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      VIC_IDLE: begin
        if (rst_pend_q) begin
          state_d = VIC_VEC_LO;                          // see RULE5
        end else if (take_mask || take_brk) begin
          state_d = VIC_PUSH_PCH;                        // see RULE1
        end
      end
      VIC_PUSH_PCH: begin
        if (acked) begin
          state_d = VIC_PUSH_PCL;
        end
      end
      VIC_PUSH_PCL: begin
        if (acked) begin
          state_d = VIC_PUSH_PS;
        end
      end
      VIC_PUSH_PS: begin
        if (acked) begin
          state_d = VIC_VEC_LO;
        end
      end
      VIC_VEC_LO: begin
        if (acked) begin
          state_d = VIC_VEC_HI;
        end
      end
      VIC_VEC_HI: begin
        if (acked) begin
          state_d = VIC_LOAD;
        end
      end
      VIC_LOAD: begin
        state_d = VIC_IDLE;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      state_q <= VIC_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // stack pointer walks down one per push
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      sp_q <= 8'h00;
    end else if (take_mask || take_brk) begin
      sp_q <= CORE_SP;
    end else if (acked && !mem_q.we) begin
      sp_q <= sp_q;
    end else if (acked) begin
      sp_q <= sp_q - 8'h01;                              // see RULE1
    end
  end

  always_comb begin
    mem_d = '0;
    unique case (state_d)
      VIC_PUSH_PCH: begin
        mem_d = '{1'b1, 1'b1, {`VIC_RST_STACKPG, sp_q}, pc_q[15:8]};
      end
      VIC_PUSH_PCL: begin
        mem_d = '{1'b1, 1'b1, {`VIC_RST_STACKPG, sp_q}, pc_q[7:0]};
      end
      VIC_PUSH_PS: begin
        mem_d = '{1'b1, 1'b1, {`VIC_RST_STACKPG, sp_q}, ps_q};
      end
      VIC_VEC_LO: begin
        mem_d = '{1'b1, 1'b0, vec_q, 8'h00};             // see RULE3
      end
      VIC_VEC_HI: begin
        mem_d = '{1'b1, 1'b0, vec_q + 16'h0001, 8'h00};
      end
      VIC_IDLE, VIC_LOAD: begin
        mem_d = '0;
      end
    endcase
  end

  // first cycle of a push uses the captured pointer, later ones the walked one
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      mem_q <= '0;
    end else if (take_mask || take_brk) begin
      mem_q <= '{1'b1, 1'b1, {`VIC_RST_STACKPG, CORE_SP}, CORE_PC[15:8]};
    end else if (state_q == VIC_PUSH_PCH || state_q == VIC_PUSH_PCL) begin
      if (acked) begin
        mem_q <= '{1'b1, 1'b1, {`VIC_RST_STACKPG, sp_q - 8'h01},
                   (state_q == VIC_PUSH_PCH) ? pc_q[7:0] : ps_q};
      end
    end else begin
      mem_q <= mem_d;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      newpc_q <= 16'h0000;
    end else if (acked && state_q == VIC_VEC_LO) begin
      newpc_q[7:0] <= MEM_RDATA;
    end else if (acked && state_q == VIC_VEC_HI) begin
      newpc_q[15:8] <= MEM_RDATA;                        // see RULE3
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb read data, captured in the setup cycle
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      prdata_q <= 32'h0000_0000;
    end else if (rd_setup && !PWRITE) begin
      prdata_q <= 32'h0000_0000;
      unique case (PADDR)
        `VIC_OFF_REQ:  prdata_q[N-1:0]           <= req_q;
        `VIC_OFF_ENA:  prdata_q[N-1:0]           <= ena_q;
        `VIC_OFF_EDGE: prdata_q[`VIC_NPIN-1:0]   <= edge_q;
        `VIC_OFF_SEL:  prdata_q[`VIC_SEL_W-1:0]  <= sel_q;
        `VIC_OFF_STAT: begin
          prdata_q[`VIC_STAT_IFLAG]             <= iflag_q;
          prdata_q[`VIC_STAT_BUSY]              <= state_q != VIC_IDLE;
          prdata_q[`VIC_STAT_BRK]               <= brk_q;
          prdata_q[`VIC_STAT_LAST+3:`VIC_STAT_LAST] <= last_q;
        end
        default: prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign PRDATA      = prdata_q;
  assign PREADY      = 1'b1;
  assign PSLVERR     = PSEL & PENABLE & ~mapped;
  assign MEM         = mem_q;
  assign CORE_HOLD   = (state_q != VIC_IDLE) | rst_pend_q;
  assign PC_LOAD     = state_q == VIC_LOAD;
  assign PC_VALUE    = newpc_q;
  assign SP_LOAD     = (state_q == VIC_LOAD) & ~from_rst_q;
  assign SP_VALUE    = sp_q;
  assign IRQ_DISABLE = iflag_q;
endmodule

// *** test/vic_checker.sv ***
module vic_checker (
  input wire logic              CORE_CLK,
  input wire logic              RST_B,
  input wire logic              PSEL,
  input wire logic              PENABLE,
  input wire logic [7:0]        PADDR,
  input wire logic              PREADY,
  input wire logic              PSLVERR,
  input wire logic [15:0]       CORE_PC,
  input wire logic [7:0]        CORE_SP,
  input wire logic              CORE_CLR_I,
  input wire vic_pkg::vic_mem_s MEM,
  input wire logic              MEM_ACK,
  input wire logic [7:0]        MEM_RDATA,
  input wire logic              CORE_HOLD,
  input wire logic              PC_LOAD,
  input wire logic [15:0]       PC_VALUE,
  input wire logic              SP_LOAD,
  input wire logic [7:0]        SP_VALUE,
  input wire logic              IRQ_DISABLE
);
  timeunit 1ns;
  timeprecision 1ps;
  import vic_pkg::*;
  logic [7:0] lo_q;
  logic [7:0] sp_q;
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);
  ////////////////////////////////////////
  // service trackers
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      lo_q <= 8'h00;
    end else if (MEM.req && !MEM.we && MEM_ACK && !MEM.addr[0]) begin
      lo_q <= MEM_RDATA;
    end
  end
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      sp_q <= 8'h00;
    end else if ($rose(MEM.req) && MEM.we) begin
      sp_q <= MEM.addr[7:0];
    end
  end
  ////////////////////////////////////////
  push_first_a: assert property ($rose(MEM.req) && MEM.we |->
    MEM.addr == {8'h01, $past(CORE_SP)} && MEM.wdata == $past(CORE_PC[15:8]))
    else $error("bad first push");
  mask_set_a: assert property ($rose(MEM.req) && MEM.we |-> IRQ_DISABLE)
    else $error("mask not set");
  stack_page_a: assert property (MEM.req && MEM.we |-> MEM.addr[15:8] == 8'h01)
    else $error("push off page");
  hold_service_a: assert property ($rose(MEM.req) |-> CORE_HOLD [*2])
    else $error("core not held");
  vec_pair_a: assert property (MEM.req && !MEM.we && MEM_ACK && !MEM.addr[0]
    |=> MEM.req && !MEM.we && MEM.addr == $past(MEM.addr) + 16'h0001)
    else $error("no vector high read");
  vec_range_a: assert property (MEM.req && !MEM.we |-> MEM.addr >= 16'hffdc)
    else $error("vector out of table");
  pc_load_a: assert property (MEM.req && !MEM.we && MEM_ACK && MEM.addr[0]
    |=> PC_LOAD && PC_VALUE == {$past(MEM_RDATA), lo_q})
    else $error("bad pc load");
  sp_value_a: assert property (SP_LOAD |-> PC_LOAD && SP_VALUE == sp_q - 8'h03)
    else $error("bad stack pointer");
  mask_clear_a: assert property ($fell(IRQ_DISABLE) |-> $past(CORE_CLR_I))
    else $error("mask cleared unasked");
  unmapped_err_a: assert property (PSEL && PENABLE && PADDR > 8'h10
    |-> PSLVERR && PREADY)
    else $error("unmapped not refused");
  cover property (SP_LOAD);
  cover property ($rose(MEM.req) && MEM.we);
  cover property (PSEL && PENABLE && PSLVERR);
endmodule

bind vic_top vic_checker u_vic_checker (
  .CORE_CLK(CORE_CLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE),
  .PADDR(PADDR), .PREADY(PREADY), .PSLVERR(PSLVERR), .CORE_PC(CORE_PC),
  .CORE_SP(CORE_SP), .CORE_CLR_I(CORE_CLR_I), .MEM(MEM), .MEM_ACK(MEM_ACK),
  .MEM_RDATA(MEM_RDATA), .CORE_HOLD(CORE_HOLD), .PC_LOAD(PC_LOAD),
  .PC_VALUE(PC_VALUE), .SP_LOAD(SP_LOAD), .SP_VALUE(SP_VALUE),
  .IRQ_DISABLE(IRQ_DISABLE)
);

// *** test/vic_core_model.sv ***
module vic_core_model (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire vic_pkg::vic_mem_s mem,
  output logic                   ack,
  output logic      [7:0]        rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  import vic_pkg::*;
  logic [1:0] wait_q;
  logic [7:0] stk [256];
  // odd addresses answer two cycles late
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack    <= 1'b0;
      wait_q <= 2'h0;
      rdata  <= 8'h00;
    end else if (mem.req && !ack && wait_q == {mem.addr[0], 1'b0}) begin
      ack    <= 1'b1;
      wait_q <= 2'h0;
      rdata  <= mem.addr[7:0] ^ 8'h5a;
      if (mem.we && mem.addr[15:8] == 8'h01) begin
        stk[mem.addr[7:0]] <= mem.wdata;
      end
    end else begin
      ack   <= 1'b0;
      rdata <= ~rdata;
      if (mem.req && !ack) begin
        wait_q <= wait_q + 2'h1;
      end
    end
  end
endmodule

// *** test/tb_top.sv ***
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import vic_pkg::*;
  logic        clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, scl = 1'b0, sda = 1'b0, soft_break_instruction = 1'b0;
  logic        set_i = 1'b0, clr_i = 1'b0;
  logic        pready, pslverr, er, ack, hold, pc_load, irq_dis;
  logic [1:0]  ctr = 2'h0;
  logic [3:0]  pins = 4'h0;
  logic [7:0]  paddr = 8'h00, sp = 8'hf0, mrd, sp_value;
  logic [15:0] pc_value;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  vic_evt_s    evt = '0;
  vic_mem_s    mem;
  int          miscompares = 0, checks_done = 0;
  always #4 clk = ~clk;
  vic_top u_vic_top (
    .CORE_CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .EXT_IRQ_PINS(pins),
    .SCL_PIN(scl), .SDA_PIN(sda), .COUNTER_PIN_ZERO(ctr[0]),
    .COUNTER_PIN_ONE(ctr[1]), .EVENTS(evt), .SOFT_BREAK_INSTRUCTION(soft_break_instruction),
    .CORE_BOUNDARY(1'b1), .CORE_PC(16'h1234), .CORE_PS(8'ha5),
    .CORE_SP(sp), .CORE_SET_I(set_i), .CORE_CLR_I(clr_i), .MEM(mem),
    .MEM_ACK(ack), .MEM_RDATA(mrd), .CORE_HOLD(hold), .PC_LOAD(pc_load),
    .PC_VALUE(pc_value), .SP_LOAD(), .SP_VALUE(sp_value),
    .IRQ_DISABLE(irq_dis)
  );
  vic_core_model u_vic_core_model (
    .clk(clk), .rst_b(rst_b), .mem(mem), .ack(ack), .rdata(mrd)
  );
  ////////////////////////////////////////
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] ex,
                     input logic [31:0] got);
    checks_done++;
    if (got !== ex) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic tmo(input string nm);
    miscompares++;
    $display("[FAIL] %s expected done seen timeout", nm);
    end_sim();
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n = 0;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) tmo("apb ready");
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] ex);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), ex, rd);
  endtask
  function automatic logic [15:0] vecval(input logic [15:0] a);
    return {(a[7:0] + 8'h01) ^ 8'h5a, a[7:0] ^ 8'h5a};
  endfunction
  task automatic wait_load();
    int n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (pc_load !== 1'b1 && n < 200);
    if (n >= 200) tmo("pc load");
  endtask
  task automatic take(input logic [15:0] va, input logic clr);
    clr_i <= clr;
    @(posedge clk);
    clr_i <= 1'b0;
    wait_load();
    chk("pc value", vecval(va), pc_value);
    chk("sp value", sp - 8'h03, sp_value);
    chk("mask flag", 1'b1, irq_dis);
    chk("push pc high", 8'h12, u_vic_core_model.stk[sp]);
    chk("push pc low", 8'h34, u_vic_core_model.stk[sp - 8'h01]);
    chk("push status", 8'ha5, u_vic_core_model.stk[sp - 8'h02]);
    @(posedge clk);
    sp <= sp - 8'h05;
  endtask
  task automatic fire(input int i);
    case (i)
      0: pins[0] <= 1'b1;
      1: scl <= 1'b1;
      2: pins[1] <= 1'b1;
      3: pins[2] <= 1'b1;
      4: pins[3] <= 1'b1;
      5: evt.i2c_done <= 1'b1;
      6: evt.tmr_x_uflow <= 1'b1;
      7: evt.tmr_y_uflow <= 1'b1;
      8: evt.tmr_1_uflow <= 1'b1;
      9: evt.tmr_2_uflow <= 1'b1;
      10: evt.sio1_rx_done <= 1'b1;
      11: evt.short_det <= 1'b1;
      12: ctr[0] <= 1'b1;
      13: ctr[1] <= 1'b1;
      14: evt.ad_done <= 1'b1;
      default: evt.sio2_rx_done <= 1'b1;
    endcase
    @(posedge clk);
    evt <= '0;
    repeat (5) @(posedge clk);
  endtask
  task automatic pulse_mask(input logic s);
    set_i <= s;
    clr_i <= !s;
    @(posedge clk);
    set_i <= 1'b0;
    clr_i <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    wait_load();
    chk("reset vector", vecval(16'hfffc), pc_value);
    @(posedge clk);
    rdc(8'h00, 32'h0);
    rdc(8'h04, 32'h0);
    rdc(8'h08, 32'h0);
    rdc(8'h0c, 32'h0);
    rdc(8'h10, 32'h1);
    rdc(8'h14, 32'h0);
    chk("unmapped error", 1'b1, er);
    $display("reset done");
    apb(1'b1, 8'h0c, 32'h06);
    apb(1'b1, 8'h04, 32'h7fff);
    for (int i = 0; i < 15; i++) begin
      fire(i);
      rdc(8'h00, 32'h1 << i);
      take(16'hfffa - 16'(2 * i), 1'b1);
      rdc(8'h00, 32'h0);
    end
    $display("sources done");
    sda <= 1'b1;
    fire(9);
    rdc(8'h00, 32'h202);
    @(negedge clk);
    chk("held off", 1'b0, hold);
    @(posedge clk);
    take(16'hfff8, 1'b1);
    take(16'hffe8, 1'b1);
    $display("priority done");
    apb(1'b1, 8'h0c, 32'h01);
    fire(5);
    rdc(8'h00, 32'h0);
    fire(15);
    rdc(8'h00, 32'h20);
    apb(1'b1, 8'h00, 32'h0);
    rdc(8'h00, 32'h0);
    apb(1'b1, 8'h00, 32'h7fff);
    rdc(8'h00, 32'h0);
    $display("select done");
    apb(1'b1, 8'h04, 32'h7fbf);
    fire(6);
    pulse_mask(1'b0);
    rdc(8'h00, 32'h40);
    apb(1'b1, 8'h00, 32'h0);
    pulse_mask(1'b1);
    apb(1'b1, 8'h04, 32'h0);
    soft_break_instruction <= 1'b1;
    @(posedge clk);
    soft_break_instruction <= 1'b0;
    take(16'hffdc, 1'b0);
    $display("break done");
    apb(1'b1, 8'h08, 32'h01);
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b1, 8'h04, 32'h01);
    pins[0] <= 1'b0;
    repeat (6) @(posedge clk);
    rdc(8'h00, 32'h1);
    take(16'hfffa, 1'b1);
    $display("edge done");
    end_sim();
  end
endmodule
